// ---- design/handler_result_if.sv ----
`timescale 1ns/1ns
`include "handler_defs.svh"
// Function
// - Port has fifteen result outputs and one trigger input.
// - Port outputs are active only in compare or binning mode.
// - A trigger rising edge while idle starts exactly one measurement; triggers while busy are ignored.
// - Ready goes high once the measurement has finished.
// - End of test goes high when conversion completes.
// - Binning drives the grade output of the bin holding the result.
// - Out-of-bins goes high when the result lies outside all bins.
// - Compare drives low output when value is below lower limit.
// - Compare drives high output when value is above upper limit.
// - Fail is high when judgment is above or below limits.
// - Pass is high when judgment lies within the limits.
// - Result retention setting offers exactly hold or clear.
// - Clear mode drops results at end-of-test fall, loads at rise.
// - Hold mode keeps previous results until current test completes.
// - Key click on/off; compare and binning beep off, pass or fail.
// - Guard enabled and high voltage seen: cut test output, warn.
// - Guard disabled: test output continues whatever the voltage.
// - Warning stays while high voltage persists, clears after removal.
// - Guard is enabled by default and on every reset.
module handler_result_if
  import handler_pkg::*;
#(
  parameter int unsigned BEEP_TICKS = `BEEP_TICKS
) (
  input  wire logic         clk_sys_i,
  input  wire logic         reset_n_i,
  input  wire logic [7:0]   addr_i,
  input  wire logic [31:0]  wr_data_i,
  input  wire logic         wr_en_i,
  input  wire logic         rd_en_i,
  output logic [31:0]       rd_data_o,
  input  wire logic         trigger_i,
  input  wire logic         key_press_i,
  input  wire logic         hv_detect_i,
  input  wire logic         conv_done_i,
  input  wire logic         meas_done_i,
  input  wire meas_result_t meas_i,
  output handler_out_t      handler_o,
  output logic              meas_start_o,
  output logic              drive_en_o,
  output logic              hv_warn_o,
  output logic              beep_o
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CONVERT,
    ST_FINISH
  } meas_state_t;

  localparam int unsigned TICK_CYC = `TICK_CYC;

  meas_state_t            state_q;
  logic [`CF_WIDTH-1:0]   ctrl_q;
  logic                   trig_prev_q;
  logic                   ready_q;
  logic                   end_of_test_q;
  handler_out_t           res_q;
  logic [15:0]            tick_cnt_q;
  logic                   tick;
  logic                   trig_rise;
  logic                   accept;
  logic                   conv;
  logic                   active;
  logic                   hold;
  logic                   guard;
  logic                   beep_fire;
  func_mode_t             func;
  handler_out_t           port_d;

  if (TICK_CYC < 1 || TICK_CYC > 65535) begin : g_tick_check
    $error("tick divider out of range");
  end

  // ----------------------------------------------------------------------
  // Result decoding.
  // ----------------------------------------------------------------------
  function automatic handler_out_t judge_decode(func_mode_t m,
                                                meas_result_t r);
    handler_out_t o;
    o = '0;
    if (m == FUNC_CMP) begin
      o.pass = (r.judge == JUDGE_IN);
      o.high = (r.judge == JUDGE_HI);
      o.low  = (r.judge == JUDGE_LO);
      o.fail = o.high | o.low;
    end else if (m == FUNC_BIN) begin
      if (r.grade >= 4'h1 && r.grade <= 4'h8) begin
        o.bin[3'(r.grade - 4'h1)] = 1'b1;
      end else begin
        o.bin_out = 1'b1;
      end
    end
    return o;
  endfunction

  function automatic logic is_pass(func_mode_t m, meas_result_t r);
    if (m == FUNC_CMP) begin
      return r.judge == JUDGE_IN;
    end
    return r.grade >= 4'h1 && r.grade <= 4'h8;
  endfunction

  assign func      = func_mode_t'(ctrl_q[`CF_FUNC]);
  assign hold      = ctrl_q[`CF_HOLD];
  assign guard     = ctrl_q[`CF_GUARD];
  assign active    = (func == FUNC_CMP) || (func == FUNC_BIN);
  assign trig_rise = trigger_i & ~trig_prev_q;
  assign accept    = (state_q == ST_IDLE) && trig_rise;
  assign conv      = (state_q == ST_CONVERT) && conv_done_i;
  assign tick      = (tick_cnt_q == 16'(TICK_CYC - 1));

  // ----------------------------------------------------------------------
  // Register port.
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_q <= `CTRL_RESET;
    end else if (wr_en_i && addr_i == `REG_CTRL_OFS) begin
      ctrl_q <= wr_data_i[`CF_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_data_o <= 32'h0;
    end else if (rd_en_i && addr_i == `REG_CTRL_OFS) begin
      rd_data_o <= {{(32-`CF_WIDTH){1'b0}}, ctrl_q};
    end else if (rd_en_i && addr_i == `REG_STATUS_OFS) begin
      rd_data_o <= {13'h0, handler_o, beep_o, drive_en_o, hv_warn_o,
                    state_q != ST_IDLE};
    end else begin
      rd_data_o <= 32'h0;
    end
  end

  // ----------------------------------------------------------------------
  // Measurement sequence.
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      trig_prev_q <= 1'b0;
    end else begin
      trig_prev_q <= trigger_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q      <= ST_IDLE;
      meas_start_o <= 1'b0;
    end else begin
      meas_start_o <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (accept) begin
            meas_start_o <= 1'b1;
            state_q      <= ST_CONVERT;
          end
        end
        ST_CONVERT: begin
          if (conv_done_i) begin
            state_q <= ST_FINISH;
          end
        end
        ST_FINISH: begin
          if (meas_done_i) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ready_q <= 1'b1;
    end else if (accept) begin
      ready_q <= 1'b0;
    end else if (state_q == ST_FINISH && meas_done_i) begin
      ready_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      end_of_test_q <= 1'b0;
    end else if (accept) begin
      end_of_test_q <= 1'b0;
    end else if (conv) begin
      end_of_test_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Result retention.
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      res_q <= '0;
    end else if (accept && !hold) begin
      res_q <= '0;
    end else if (conv) begin
      res_q <= judge_decode(func, meas_i);
    end
  end

  always_comb begin
    port_d             = res_q;
    port_d.ready       = ready_q;
    port_d.end_of_test = end_of_test_q;
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      handler_o <= '0;
    end else if (active) begin
      handler_o <= port_d;
    end else begin
      handler_o <= '0;
    end
  end

  // ----------------------------------------------------------------------
  // High voltage guard.
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      drive_en_o <= 1'b1;
      hv_warn_o  <= 1'b0;
    end else begin
      drive_en_o <= !(guard && hv_detect_i);
      hv_warn_o  <= guard && hv_detect_i;
    end
  end

  // ----------------------------------------------------------------------
  // Beeper.
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tick_cnt_q <= 16'h0;
    end else if (tick) begin
      tick_cnt_q <= 16'h0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 16'h1;
    end
  end

  always_comb begin
    beep_sel_t sel;
    sel = beep_sel_t'(func == FUNC_BIN ? ctrl_q[`CF_BIN_BEEP]
                                       : ctrl_q[`CF_CMP_BEEP]);
    beep_fire = (key_press_i && ctrl_q[`CF_CLICK]) ||
                (conv && active &&
                 ((sel == BEEP_PASS && is_pass(func, meas_i)) ||
                  (sel == BEEP_FAIL && !is_pass(func, meas_i))));
  end

  beep_timer #(
    .TICKS (BEEP_TICKS)
  ) u_beep (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .tick_i    (tick),
    .fire_i    (beep_fire),
    .beep_o    (beep_o)
  );

  // ----------------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------------
  sequence s_accept;
    accept;
  endsequence

  sequence s_conv;
    conv;
  endsequence

  a_trig_one_start: assert property (@(posedge clk_sys_i)
    disable iff (!reset_n_i)
    s_accept |=> meas_start_o ##1 !meas_start_o)
    else $error("trigger did not give one start pulse");

  a_ready_on_done: assert property (@(posedge clk_sys_i)
    disable iff (!reset_n_i)
    (state_q == ST_FINISH && meas_done_i && active) |=> ##1 handler_o.ready)
    else $error("ready not raised after measurement");

  a_test_end_conv: assert property (@(posedge clk_sys_i)
    disable iff (!reset_n_i)
    (s_conv ##0 active) |=> ##1 handler_o.end_of_test)
    else $error("end of test not raised after conversion");

  a_bin_one_hot: assert property (@(posedge clk_sys_i)
    disable iff (!reset_n_i)
    $onehot0({handler_o.bin, handler_o.bin_out}))
    else $error("more than one grade output high");

  a_port_inactive: assert property (@(posedge clk_sys_i)
    disable iff (!reset_n_i)
    !active |=> handler_o == '0)
    else $error("handler outputs active outside compare or binning");

  a_fail_equals: assert property (@(posedge clk_sys_i)
    disable iff (!reset_n_i)
    handler_o.fail == (handler_o.high | handler_o.low))
    else $error("fail does not match high or low");

  a_clear_drop: assert property (@(posedge clk_sys_i)
    disable iff (!reset_n_i)
    (s_accept ##0 !hold) |=> res_q == '0)
    else $error("results not cleared in clear mode");

  a_hold_keep: assert property (@(posedge clk_sys_i)
    disable iff (!reset_n_i)
    (s_accept ##0 hold) |=> $stable(res_q))
    else $error("results changed before completion in hold mode");

  a_guard_cut: assert property (@(posedge clk_sys_i)
    disable iff (!reset_n_i)
    (guard && hv_detect_i) |=> (!drive_en_o && hv_warn_o))
    else $error("guard did not cut output");

  a_guard_off: assert property (@(posedge clk_sys_i)
    disable iff (!reset_n_i)
    !guard |=> (drive_en_o && !hv_warn_o))
    else $error("output cut while guard disabled");

  a_guard_reset: assert property (@(posedge clk_sys_i)
    $rose(reset_n_i) |-> guard)
    else $error("guard not enabled after reset");

endmodule

// ---- design/handler_defs.svh ----
`ifndef HANDLER_DEFS_SVH
`define HANDLER_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define REG_CTRL_OFS    8'h00
`define REG_STATUS_OFS  8'h04

// ----------------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------------
`define CF_FUNC         1:0
`define CF_HOLD         2
`define CF_CLICK        3
`define CF_CMP_BEEP     5:4
`define CF_BIN_BEEP     7:6
`define CF_GUARD        8
`define CF_WIDTH        9

// ----------------------------------------------------------------------
// Status field positions
// ----------------------------------------------------------------------
`define SF_BUSY         0
`define SF_WARN         1
`define SF_DRIVE        2
`define SF_BEEP         3
`define SF_PORT         18:4

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CTRL_RESET      9'h100

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS   10
`define TICK_NS         1000
`define TICK_CYC        (`TICK_NS / `CLK_PERIOD_NS)
`define BEEP_MS         100
`define BEEP_TICKS      (`BEEP_MS * 1000)

`endif

// ---- design/handler_pkg.sv ----
package handler_pkg;

  typedef enum logic [1:0] {
    FUNC_NONE = 2'h0,
    FUNC_CMP  = 2'h1,
    FUNC_BIN  = 2'h2
  } func_mode_t;

  typedef enum logic [1:0] {
    BEEP_OFF  = 2'h0,
    BEEP_PASS = 2'h1,
    BEEP_FAIL = 2'h2
  } beep_sel_t;

  typedef enum logic [1:0] {
    JUDGE_IN = 2'h0,
    JUDGE_HI = 2'h1,
    JUDGE_LO = 2'h2
  } judge_t;

  typedef struct packed {
    judge_t     judge;
    logic [3:0] grade;
  } meas_result_t;

  typedef struct packed {
    logic       ready;
    logic       end_of_test;
    logic       pass;
    logic       fail;
    logic       high;
    logic       low;
    logic [7:0] bin;
    logic       bin_out;
  } handler_out_t;

endpackage

// ---- design/beep_timer.sv ----
`timescale 1ns/1ns
module beep_timer #(
  parameter int unsigned TICKS = 100000
) (
  input  wire logic clk_sys_i,
  input  wire logic reset_n_i,
  input  wire logic tick_i,
  input  wire logic fire_i,
  output logic      beep_o
);

  logic [31:0] cnt_q;

  if (TICKS < 1) begin : g_ticks_check
    $error("beep_timer needs at least one tick");
  end

  // ----------------------------------------------------------------------
  // One-shot tone length counter.
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_q  <= 32'h0;
      beep_o <= 1'b0;
    end else if (fire_i) begin
      cnt_q  <= TICKS;
      beep_o <= 1'b1;
    end else if (tick_i && cnt_q != 32'h0) begin
      cnt_q  <= cnt_q - 32'h1;
      beep_o <= (cnt_q != 32'h1);
    end
  end

endmodule

// ---- dv/meas_engine_model.sv ----
`timescale 1ns/1ns
module meas_engine_model
  import handler_pkg::*;
(
  input  wire logic         clk_sys_i,
  input  wire logic         reset_n_i,
  input  wire logic         start_i,
  input  wire meas_result_t result_i,
  input  wire logic [3:0]   conv_wait_i,
  input  wire logic [3:0]   fin_wait_i,
  output logic              conv_done_o,
  output logic              meas_done_o,
  output meas_result_t      meas_o
);
  // ------------------------------------------------------------------
  // Measurement engine
  // ------------------------------------------------------------------
  logic [3:0] cnt_q;
  logic [1:0] phase_q;

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phase_q     <= 2'h0;
      cnt_q       <= 4'h0;
      conv_done_o <= 1'b0;
      meas_done_o <= 1'b0;
      meas_o      <= '0;
    end else begin
      conv_done_o <= 1'b0;
      meas_done_o <= 1'b0;
      meas_o      <= ~meas_o;
      case (phase_q)
        2'h0: if (start_i) begin
          phase_q <= 2'h1;
          cnt_q   <= conv_wait_i;
        end
        2'h1: if (cnt_q == 4'h0) begin
          conv_done_o <= 1'b1;
          meas_o      <= result_i;
          phase_q     <= 2'h2;
          cnt_q       <= fin_wait_i;
        end else begin
          cnt_q <= cnt_q - 4'h1;
        end
        default: if (cnt_q == 4'h0) begin
          meas_done_o <= 1'b1;
          phase_q     <= 2'h0;
        end else begin
          cnt_q <= cnt_q - 4'h1;
        end
      endcase
    end
  end
endmodule

// ---- dv/handler_result_interface_test.sv ----
`timescale 1ns/1ns
module handler_result_interface_test
  import handler_pkg::*;
;
  logic         clk = 0;
  logic         rst_n = 0;
  logic [7:0]   addr = '0;
  logic [31:0]  wdat = '0;
  logic         wr = 0, rd = 0, trig = 0, key = 0, hv = 0;
  logic [31:0]  rdat;
  logic         cdone, mdone, mstart, drv, warn, beep;
  meas_result_t meas, res = '0;
  handler_out_t hout;
  logic [3:0]   cw = '0, fw = '0;
  int           num_errors = 0, checks = 0, starts = 0, cyc = 0;
  logic [1:0]   lastf = 2'h0;

  handler_result_if #(.BEEP_TICKS(3)) u_dut (.clk_sys_i(clk),
    .reset_n_i(rst_n), .addr_i(addr), .wr_data_i(wdat), .wr_en_i(wr),
    .rd_en_i(rd), .rd_data_o(rdat), .trigger_i(trig), .key_press_i(key),
    .hv_detect_i(hv), .conv_done_i(cdone), .meas_done_i(mdone),
    .meas_i(meas), .handler_o(hout), .meas_start_o(mstart),
    .drive_en_o(drv), .hv_warn_o(warn), .beep_o(beep));
  meas_engine_model u_eng (.clk_sys_i(clk), .reset_n_i(rst_n),
    .start_i(mstart), .result_i(res), .conv_wait_i(cw), .fin_wait_i(fw),
    .conv_done_o(cdone), .meas_done_o(mdone), .meas_o(meas));

  always #5 clk = ~clk;

  always @(posedge clk) begin
    cyc++;
    if (mstart === 1'b1) starts++;
    if (cyc == 30000) begin
      num_errors++;
      end_of_test();
    end
  end

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdat <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("rd_data", e, rdat);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wait_out(input int i, input logic v, input int lim);
    int n;
    n = 0;
    while (hout[i] !== v && n < lim) begin
      tick(1);
      n++;
    end
    chk("handler_o bit", 32'(v), 32'(hout[i]));
  endtask

  function automatic logic [12:0] exp_res(input logic [1:0] f,
                                          input meas_result_t m);
    logic [12:0] r;
    r = '0;
    if (f == FUNC_CMP) begin
      r[12] = m.judge == JUDGE_IN;
      r[11] = m.judge != JUDGE_IN;
      r[10] = m.judge == JUDGE_HI;
      r[9]  = m.judge == JUDGE_LO;
    end else if (f == FUNC_BIN) begin
      if (m.grade >= 4'h1 && m.grade <= 4'h8) r[m.grade] = 1'b1;
      else r[0] = 1'b1;
    end
    return r;
  endfunction

  task automatic run(input logic [8:0] c, input meas_result_t m);
    logic [12:0] prev;
    int s;
    wr_reg(8'h00, 32'(c));
    tick(2);
    prev = hout[12:0];
    s = starts;
    res <= m;
    cw <= 4'($urandom_range(8));
    fw <= 4'($urandom_range(3));
    trig <= 1'b1;
    tick(1);
    chk("meas_start", 1, mstart);
    tick(1);
    trig <= 1'b0;
    chk("ready", 0, hout.ready);
    chk("end_of_test", 0, hout.end_of_test);
    if (!c[2]) chk("cleared", 0, hout[12:0]);
    if (c[2] && c[1:0] == lastf) chk("held", prev, hout[12:0]);
    tick(1);
    trig <= 1'b1;
    tick(1);
    trig <= 1'b0;
    wait_out(13, 1'b1, 40);
    chk("results", exp_res(c[1:0], m), hout[12:0]);
    wait_out(14, 1'b1, 40);
    chk("one start", s + 1, starts);
    lastf = c[1:0];
  endtask

  task automatic end_of_test();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------------
  logic [8:0] bctl [6] = '{9'h111, 9'h121, 9'h121, 9'h182, 9'h142, 9'h102};
  logic [5:0] bmeas[6] = '{6'h00, 6'h00, 6'h10, 6'h00, 6'h03, 6'h03};
  logic       bexp [6] = '{1, 0, 1, 1, 1, 0};

  initial begin
    meas_result_t m;
    void'($urandom(32'h3AAF));
    tick(6);
    rst_n <= 1'b1;
    tick(1);
    chk("idle out", 0, hout);
    chk("drive", 1, drv);
    rd_reg(8'h00, 32'h100);
    rd_reg(8'h04, 32'h4);
    wr_reg(8'h08, 32'hFF);
    rd_reg(8'h08, 32'h0);
    rd_reg(8'h00, 32'h100);
    $display("test registers done");
    for (int i = 0; i < 26; i++) begin
      m.judge = judge_t'(2'(i < 3 ? i : $urandom_range(2)));
      m.grade = 4'(i < 23 ? i - 13 : $urandom_range(15));
      run({6'h20, 1'($urandom_range(1)), i < 13 ? 2'h1 : 2'h2}, m);
    end
    $display("test results done");
    for (int f = 0; f < 4; f += 3) begin
      wr_reg(8'h00, 32'h100 | f);
      tick(3);
      chk("off mode", 0, hout);
    end
    $display("test modes done");
    key <= 1'b1;
    tick(1);
    key <= 1'b0;
    tick(1);
    chk("no click", 0, beep);
    wr_reg(8'h00, 32'h109);
    key <= 1'b1;
    tick(1);
    key <= 1'b0;
    tick(1);
    chk("click", 1, beep);
    for (int i = 0; i < 6; i++) begin
      tick(500);
      run(bctl[i], meas_result_t'(bmeas[i]));
      chk("beep", 32'(bexp[i]), 32'(beep));
    end
    $display("test beep done");
    hv <= 1'b1;
    tick(2);
    chk("cut", 0, drv);
    tick(20);
    chk("warn", 1, warn);
    hv <= 1'b0;
    tick(2);
    chk("warn off", 0, warn);
    chk("drive back", 1, drv);
    wr_reg(8'h00, 32'h001);
    hv <= 1'b1;
    tick(3);
    chk("no cut", 1, drv);
    rst_n <= 1'b0;
    tick(2);
    rst_n <= 1'b1;
    tick(3);
    chk("guard again", 0, drv);
    rd_reg(8'h00, 32'h100);
    hv <= 1'b0;
    $display("test guard done");
    end_of_test();
  end
endmodule
